// *** rtl/fqd_pkg.sv ***
// Constants, carrier types and demultiplex configuration for the FEC and diversity back end
package fqd_pkg;

   // Block code shape: 140 information bytes in a 160-byte codeword
   localparam int          RS_N      = 160;
   localparam int          RS_K      = 140;
   localparam int          RS_PAR    = RS_N - RS_K;
   localparam logic [8:0]  GF_POLY   = 9'h11d;
   localparam logic [7:0]  GF_ALPHA  = 8'h02;

   // Convolutional code, rate 1/2, constraint length 7
   localparam int          CL_MEM    = 6;
   localparam int          CL_STATES = 64;
   localparam logic [6:0]  CL_G0     = 7'h79;
   localparam logic [6:0]  CL_G1     = 7'h5b;

   // Metric values loaded at frame start
   localparam logic [7:0]  PM_START  = 8'h00;
   localparam logic [7:0]  PM_OTHER  = 8'h20;

   // One byte with its block quality
   typedef struct packed {
      logic [7:0] data;
      logic       bad;
   } fqd_byte_type;

   // Demultiplex layout of one transmission identifier
   typedef struct packed {
      logic [1:0] last;
      logic [1:0] aud;
      logic [1:0] dly;
      logic [1:0] dat;
      logic       div;
      logic       has_data;
   } fqd_cfg_type;

   // Configuration lookup from the transmission identifier
   function automatic fqd_cfg_type fqd_cfg(input logic [3:0] id);
      fqd_cfg_type c;
      c = '{last: 2'h0, aud: 2'h0, dly: 2'h0, dat: 2'h0, div: 1'b0, has_data: 1'b0};
      case (id)
         4'h1:    c = '{last: 2'h1, aud: 2'h0, dly: 2'h0, dat: 2'h1, div: 1'b0, has_data: 1'b1};
         4'h2:    c = '{last: 2'h1, aud: 2'h0, dly: 2'h1, dat: 2'h0, div: 1'b1, has_data: 1'b0};
         4'h3:    c = '{last: 2'h2, aud: 2'h0, dly: 2'h1, dat: 2'h2, div: 1'b1, has_data: 1'b1};
         default: c = '{last: 2'h0, aud: 2'h0, dly: 2'h0, dat: 2'h0, div: 1'b0, has_data: 1'b0};
      endcase
      return c;
   endfunction : fqd_cfg

   // Multiply in GF(256)
   function automatic logic [7:0] fqd_gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ x;
         x = x[7] ? (8'({x, 1'b0}) ^ GF_POLY[7:0]) : 8'({x, 1'b0});
      end
      return p;
   endfunction : fqd_gf_mul

   // Power of the field generator
   function automatic logic [7:0] fqd_gf_pow(input int e);
      logic [7:0] r;
      r = 8'h01;
      for (int i = 0; i < e; i++)
         r = fqd_gf_mul(r, GF_ALPHA);
      return r;
   endfunction : fqd_gf_pow

endpackage : fqd_pkg

// *** rtl/fqd_back_end.sv ***
// Viterbi decoding, block check, demultiplexing and diversity selection of the receiver back end
`timescale 1ns/10ps

module fqd_back_end
   import fqd_pkg::*;
#(
   parameter int TB   = 32,
   parameter int DIVB = 2,
   parameter int AUDM = 70
)
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         frame_start,
   input  wire logic [3:0]   tx_id,
   input  wire logic         sym_valid,
   input  wire logic [1:0]   sym_bits,
   input  wire fqd_byte_type peer,
   input  wire logic         peer_valid,
   output logic              peer_take,
   output fqd_byte_type      audio,
   output logic              audio_stb,
   output fqd_byte_type      data_out,
   output logic              data_stb,
   output logic              blk_done,
   output logic              blk_bad
);

   localparam int WPW = (DIVB > 1) ? $clog2(DIVB) : 1;

   typedef struct packed {
      logic [CL_STATES-1:0][7:0]      pm;
      logic [CL_STATES-1:0][TB-1:0]   surv;
      logic [7:0]                     fill;
      logic [7:0]                     sh;
      logic [2:0]                     bitc;
      logic [7:0]                     bytec;
      logic [RS_PAR-1:0][7:0]         syn;
      logic [1:0][RS_K-1:0][7:0]      bank;
      logic [1:0]                     bank_bad;
      logic                           wb;
      logic                           emit;
      logic                           eb;
      logic [7:0]                     ei;
      fqd_cfg_type                    cfg;
      logic [1:0]                     slot;
      logic [6:0]                     k;
      logic [DIVB-1:0][AUDM-1:0][7:0] ring;
      logic [DIVB-1:0]                ring_bad;
      logic [WPW-1:0]                 wp;
      logic [7:0]                     hold;
      logic                           hold_bad;
      fqd_byte_type                   audio;
      logic                           audio_stb;
      fqd_byte_type                   data;
      logic                           data_stb;
      logic                           blk_done;
      logic                           blk_bad;
   } fqd_state_type;

   fqd_state_type state;
   fqd_state_type next_state;

   logic [5:0]   ns_idx;
   logic [5:0]   p0;
   logic [5:0]   p1;
   logic [7:0]   m0;
   logic [7:0]   m1;
   logic [5:0]   best;
   logic         dec_bit;
   logic [7:0]   new_byte;
   logic [7:0]   eb_byte;
   logic         eb_bad;
   logic         own_stb;
   fqd_byte_type own;

   // Branch metric: distance of the expected code pair from the received pair
   function automatic logic [1:0] branch(input logic [5:0] s, input logic u, input logic [1:0] rx);
      logic [6:0] r;
      logic [1:0] c;
      r = {s, u};
      c = {^(r & CL_G1), ^(r & CL_G0)};
      return {1'b0, c[0] ^ rx[0]} + {1'b0, c[1] ^ rx[1]};
   endfunction : branch

   // Wrapping metric compare, a is better than b
   function automatic logic better(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      return d[7];
   endfunction : better

   // Next-state logic of the whole back end
   always_comb
   begin
      next_state = state;
      ns_idx = 6'h00;
      p0 = 6'h00;
      p1 = 6'h00;
      m0 = 8'h00;
      m1 = 8'h00;
      best = 6'h00;
      dec_bit = 1'b0;
      new_byte = 8'h00;
      eb_byte = 8'h00;
      eb_bad = 1'b0;
      own_stb = 1'b0;
      own = '{data: 8'h00, bad: 1'b1};
      next_state.audio_stb = 1'b0;
      next_state.data_stb = 1'b0;
      next_state.blk_done = 1'b0;

      // Add-compare-select over all states, register exchange survivors
      if (sym_valid && !frame_start)
      begin
         for (int s = 0; s < CL_STATES; s++)
         begin
            ns_idx = 6'(s);
            p0 = {1'b0, ns_idx[5:1]};
            p1 = {1'b1, ns_idx[5:1]};
            m0 = state.pm[p0] + {6'h00, branch(p0, ns_idx[0], sym_bits)};
            m1 = state.pm[p1] + {6'h00, branch(p1, ns_idx[0], sym_bits)};
            if (better(m1, m0))
            begin
               next_state.pm[s] = m1;
               next_state.surv[s] = {state.surv[p1][TB-2:0], ns_idx[0]};
            end
            else
            begin
               next_state.pm[s] = m0;
               next_state.surv[s] = {state.surv[p0][TB-2:0], ns_idx[0]};
            end
         end
         for (int s = 1; s < CL_STATES; s++)
            if (better(next_state.pm[s], next_state.pm[best]))
               best = 6'(s);
         dec_bit = next_state.surv[best][TB-1];
         // Survivor register holds the first bit after TB symbols
         if (state.fill < 8'(TB - 1))
            next_state.fill = state.fill + 8'h01;
         else
         begin
            // Decoded bits packed MSB first into codeword bytes
            next_state.sh = {state.sh[6:0], dec_bit};
            next_state.bitc = state.bitc + 3'h1;
            if (state.bitc == 3'h7)
            begin
               new_byte = {state.sh[6:0], dec_bit};
               for (int j = 0; j < RS_PAR; j++)
                  next_state.syn[j] = fqd_gf_mul(state.syn[j], fqd_gf_pow(j)) ^ new_byte;
               if (state.bytec < 8'(RS_K))
                  next_state.bank[state.wb][state.bytec] = new_byte;
               next_state.bytec = state.bytec + 8'h01;
               if (state.bytec == 8'(RS_N - 1))
               begin
                  // Codeword end: any nonzero syndrome marks the block bad
                  next_state.bank_bad[state.wb] = |next_state.syn;
                  next_state.blk_bad = |next_state.syn;
                  next_state.blk_done = 1'b1;
                  next_state.syn = '0;
                  next_state.bytec = 8'h00;
                  next_state.wb = ~state.wb;
                  next_state.emit = 1'b1;
                  next_state.eb = state.wb;
                  next_state.ei = 8'h00;
                  next_state.slot = 2'h0;
                  next_state.k = 7'h00;
               end
            end
         end
      end

      // Frame start restarts the decoder and loads the layout
      if (frame_start)
      begin
         for (int s = 0; s < CL_STATES; s++)
            next_state.pm[s] = (s == 0) ? PM_START : PM_OTHER;
         next_state.fill = 8'h00;
         next_state.bitc = 3'h0;
         next_state.bytec = 8'h00;
         next_state.syn = '0;
         next_state.cfg = fqd_cfg(tx_id);
      end

      // Emission of a checked block through the demultiplexer
      if (state.emit)
      begin
         eb_byte = state.bank[state.eb][state.ei];
         eb_bad = state.bank_bad[state.eb];
         if (state.cfg.has_data && state.slot == state.cfg.dat)
         begin
            next_state.data = '{data: eb_byte, bad: eb_bad};
            next_state.data_stb = 1'b1;
         end
         if (state.slot == state.cfg.aud)
         begin
            if (!state.cfg.div)
            begin
               own = '{data: eb_byte, bad: eb_bad};
               own_stb = 1'b1;
            end
            else if (state.k < 7'(AUDM))
            begin
               // Real-time copy waits DIVB blocks to meet its delayed copy
               next_state.hold = state.ring[state.wp][state.k];
               next_state.hold_bad = state.ring_bad[state.wp];
               next_state.ring[state.wp][state.k] = eb_byte;
            end
         end
         if (state.cfg.div && state.slot == state.cfg.dly && state.k < 7'(AUDM))
         begin
            // Delayed copy wins only when it is good and the real-time one is not
            if (state.hold_bad && !eb_bad)
               own = '{data: eb_byte, bad: 1'b0};
            else
               own = '{data: state.hold, bad: state.hold_bad};
            own_stb = 1'b1;
            next_state.k = state.k + 7'h01;
         end
         next_state.slot = (state.slot == state.cfg.last) ? 2'h0 : state.slot + 2'h1;
         next_state.ei = state.ei + 8'h01;
         if (state.ei == 8'(RS_K - 1))
         begin
            next_state.emit = 1'b0;
            if (state.cfg.div)
            begin
               next_state.ring_bad[state.wp] = eb_bad;
               next_state.wp = (state.wp == WPW'(DIVB - 1)) ? '0 : state.wp + WPW'(1);
            end
         end
      end

      // Output stage: peer receiver replaces a bad own byte
      if (own_stb)
      begin
         if (peer_valid && own.bad && !peer.bad)
            next_state.audio = peer;
         else
            next_state.audio = own;
         next_state.audio_stb = 1'b1;
      end
   end

   // Peer byte consumed whenever an audio byte is produced while peer_valid is high
   assign peer_take = own_stb && peer_valid;

   // State register
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= '0;
         state.ring_bad <= '1;
         state.hold_bad <= 1'b1;
         state.audio.bad <= 1'b1;
      end
      else
         state <= next_state;
   end

   // Registered outputs
   assign audio     = state.audio;
   assign audio_stb = state.audio_stb;
   assign data_out  = state.data;
   assign data_stb  = state.data_stb;
   assign blk_done  = state.blk_done;
   assign blk_bad   = state.blk_bad;

endmodule : fqd_back_end

// *** bench/fqd_back_end_monitor.sv ***
// Port checker for the receiver back end
`timescale 1ns/10ps
module fqd_back_end_monitor
   import fqd_pkg::*;
(
   input wire logic         mclk,
   input wire logic         rst,
   input wire logic         frame_start,
   input wire logic         peer_valid,
   input wire logic         peer_take,
   input wire fqd_byte_type audio,
   input wire logic         audio_stb,
   input wire fqd_byte_type data_out,
   input wire logic         data_stb,
   input wire logic         blk_done,
   input wire logic         blk_bad
);
   logic [11:0] since;
   // Cycles since the last finished block, saturating
   always_ff @(posedge mclk)
   begin
      if (rst)
         since <= 12'hfff;
      else if (blk_done)
         since <= 12'h001;
      else if (since != 12'hfff)
         since <= since + 12'h001;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_bad_hold: assert property (!blk_done |-> $stable(blk_bad))
      else $error("blk_bad moved without blk_done");
   a_blk_apart: assert property (blk_done |=> !blk_done [*8])
      else $error("blocks finished too close");
   a_frame_gap: assert property (frame_start |-> ##2 !blk_done [*8])
      else $error("block done right after frame start");
   a_aud_window: assert property (audio_stb |-> since inside {[1:140]})
      else $error("audio byte outside emission");
   a_dat_window: assert property (data_stb |-> since >= 12'h001 && since <= 12'h08c)
      else $error("data byte outside emission");
   a_dat_tag: assert property (data_stb && !blk_done |-> data_out.bad == blk_bad)
      else $error("data byte tag differs from block flag");
   a_peer_take: assert property (peer_take |-> peer_valid ##1 audio_stb)
      else $error("peer taken without audio byte");
   a_aud_hold: assert property (!audio_stb |-> $stable(audio))
      else $error("audio moved without strobe");
   c_bad_blk: cover property (blk_done && blk_bad);
   c_peer: cover property (peer_take);
   c_data: cover property (data_stb);
endmodule : fqd_back_end_monitor

bind fqd_back_end fqd_back_end_monitor fqd_back_end_monitor_i (.mclk(mclk), .rst(rst),
   .frame_start(frame_start), .peer_valid(peer_valid), .peer_take(peer_take), .audio(audio),
   .audio_stb(audio_stb), .data_out(data_out), .data_stb(data_stb), .blk_done(blk_done),
   .blk_bad(blk_bad));

// *** bench/fqd_out_sink.sv ***
// Audio decoder and data output model at the far side
`timescale 1ns/10ps
module fqd_out_sink
   import fqd_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         mute_en,
   input  wire fqd_byte_type audio,
   input  wire logic         audio_stb,
   output logic              mute,
   output logic [7:0]        aux_bits
);
   // Mute on bad quality when enabled, aux bit from each audio byte
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mute <= 1'b1;
         aux_bits <= 8'h00;
      end
      else if (audio_stb)
      begin
         mute <= mute_en & audio.bad;
         aux_bits <= {aux_bits[6:0], audio.data[0]};
      end
   end
endmodule : fqd_out_sink

// *** bench/tb.sv ***
// Self-checking bench for the receiver back end
`timescale 1ns/10ps
module tb;
   import fqd_pkg::*;
   logic         mclk = 1'b0;
   logic         rst = 1'b1;
   logic         frame_start = 1'b0;
   logic [3:0]   tx_id = 4'h0;
   logic         sym_valid = 1'b0;
   logic [1:0]   sym_bits = 2'h0;
   fqd_byte_type peer = '{data: 8'hc3, bad: 1'b0};
   logic         peer_valid = 1'b1;
   logic         peer_take, audio_stb, data_stb, blk_done, blk_bad, mute;
   fqd_byte_type audio, data_out;
   logic [7:0]   aux_bits;
   int           bad_count = 0;
   int           cmp_count = 0;
   logic [7:0]   cw [160];
   logic [7:0]   gp [21];
   logic [5:0]   sr;
   logic [8:0]   q_aud [$];
   logic [8:0]   q_dat [$];
   logic         q_bb [$];

   always #2.5 mclk = ~mclk;

   fqd_back_end #(.TB(8), .DIVB(1), .AUDM(70)) fqd_back_end_i (.mclk(mclk), .rst(rst),
      .frame_start(frame_start), .tx_id(tx_id), .sym_valid(sym_valid), .sym_bits(sym_bits),
      .peer(peer), .peer_valid(peer_valid), .peer_take(peer_take), .audio(audio),
      .audio_stb(audio_stb), .data_out(data_out), .data_stb(data_stb), .blk_done(blk_done),
      .blk_bad(blk_bad));
   fqd_out_sink fqd_out_sink_i (.mclk(mclk), .rst(rst), .mute_en(1'b1), .audio(audio),
      .audio_stb(audio_stb), .mute(mute), .aux_bits(aux_bits));

   // Field multiply for the parity model
   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ a;
         a = a[7] ? ({a[6:0], 1'b0} ^ GF_POLY[7:0]) : {a[6:0], 1'b0};
      end
      return p;
   endfunction : gmul

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Generator polynomial with roots from alpha^0 up
   task automatic make_gen;
      logic [7:0] r;
      r = 8'h01;
      gp = '{default: 8'h00};
      gp[0] = 8'h01;
      for (int i = 0; i < RS_PAR; i++)
      begin
         for (int j = RS_PAR; j > 0; j--)
            gp[j] = gp[j - 1] ^ gmul(gp[j], r);
         gp[0] = gmul(gp[0], r);
         r = gmul(r, GF_ALPHA);
      end
   endtask : make_gen

   // Codeword of block n, last parity byte spoiled when bad
   task automatic make_cw(input int n, input logic bad);
      logic [7:0] p [20];
      logic [7:0] fb;
      p = '{default: 8'h00};
      for (int i = 0; i < RS_K; i++)
      begin
         cw[i] = 8'(n * 29 + i * 7 + 17);
         fb = cw[i] ^ p[19];
         for (int j = 19; j > 0; j--)
            p[j] = p[j - 1] ^ gmul(fb, gp[j]);
         p[0] = gmul(fb, gp[0]);
      end
      for (int j = 0; j < RS_PAR; j++)
         cw[RS_K + j] = p[19 - j];
      cw[RS_N - 1] ^= {7'h00, bad};
   endtask : make_cw

   // Convolutional encode of one bit into one symbol
   task automatic send_bit(input logic b);
      logic [6:0] w;
      w = {sr, b};
      @(negedge mclk);
      sym_valid = 1'b1;
      sym_bits = {^(w & CL_G1), ^(w & CL_G0)};
      sr = {sr[4:0], b};
   endtask : send_bit

   task automatic send_cw;
      for (int i = 0; i < RS_N * 8; i++)
         send_bit(cw[i / 8][7 - i % 8]);
   endtask : send_cw

   task automatic start_frame(input logic [3:0] id);
      @(negedge mclk);
      sym_valid = 1'b0;
      frame_start = 1'b1;
      tx_id = id;
      @(negedge mclk);
      frame_start = 1'b0;
      sr = 6'h00;
   endtask : start_frame

   // Tail symbols, then wait for all expected outputs
   task automatic finish_frame;
      int k;
      for (k = 0; k < 8; k++)
         send_bit(1'b0);
      @(negedge mclk);
      sym_valid = 1'b0;
      k = 0;
      while (q_aud.size() + q_dat.size() + q_bb.size() != 0 && k < 400)
      begin
         @(negedge mclk);
         k++;
      end
      chk(9'(q_aud.size() + q_dat.size() + q_bb.size()), 9'h000);
   endtask : finish_frame

   // Four diversity blocks: good, good, bad, bad; peer covers the last
   task automatic t_diversity;
      logic [7:0] prev [160];
      start_frame(4'h3);
      for (int n = 0; n < 4; n++)
      begin
         make_cw(n, n > 1);
         q_bb.push_back(n > 1);
         for (int k = 0; k < 47; k++)
            q_aud.push_back(n == 0 ? {cw[3 * k + 1], 1'b0} : n == 3 ? 9'h186 : {prev[3 * k], 1'b0});
         for (int k = 0; k < 46; k++)
            q_dat.push_back({cw[3 * k + 2], n > 1});
         prev = cw;
         send_cw();
      end
      finish_frame();
   endtask : t_diversity

   // One audio-only block, every byte to audio, no data bytes
   task automatic t_single;
      logic [7:0] ax;
      start_frame(4'h0);
      make_cw(5, 1'b0);
      q_bb.push_back(1'b0);
      for (int i = 0; i < RS_K; i++)
         q_aud.push_back({cw[i], 1'b0});
      send_cw();
      finish_frame();
      // Sink state once the last byte has been clocked in
      @(negedge mclk);
      ax = 8'h00;
      for (int i = RS_K - 8; i < RS_K; i++)
         ax = {ax[6:0], cw[i][0]};
      chk({8'h00, mute}, 9'h000);
      chk({1'b0, aux_bits}, {1'b0, ax});
   endtask : t_single

   // Audio and data slots of a bad block with no peer, then two-slot diversity
   task automatic t_modes;
      logic [7:0] prev [160];
      peer_valid = 1'b0;
      start_frame(4'h1);
      make_cw(6, 1'b1);
      q_bb.push_back(1'b1);
      for (int k = 0; k < 70; k++)
      begin
         q_aud.push_back({cw[2 * k], 1'b1});
         q_dat.push_back({cw[2 * k + 1], 1'b1});
      end
      send_cw();
      finish_frame();
      @(negedge mclk);
      chk({8'h00, mute}, 9'h001);
      peer_valid = 1'b1;
      start_frame(4'h2);
      for (int n = 0; n < 2; n++)
      begin
         make_cw(n + 7, 1'b0);
         q_bb.push_back(1'b0);
         for (int k = 0; k < 70; k++)
            q_aud.push_back({n == 0 ? cw[2 * k + 1] : prev[2 * k], 1'b0});
         prev = cw;
         send_cw();
      end
      finish_frame();
   endtask : t_modes

   // Outputs against expectations
   always @(negedge mclk)
   begin
      if (audio_stb === 1'b1)
         chk(audio, q_aud.size() ? q_aud.pop_front() : 9'h1ff);
      if (data_stb === 1'b1)
         chk(data_out, q_dat.size() ? q_dat.pop_front() : 9'h1ff);
      if (blk_done === 1'b1)
         chk({8'h00, blk_bad}, q_bb.size() ? {8'h00, q_bb.pop_front()} : 9'h1ff);
   end

   task automatic final_report;
      $display("Counts: %0d mismatches in %0d comparisons", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      make_gen();
      sr = 6'h00;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      t_diversity();
      t_single();
      t_modes();
      final_report();
   end

   // Watchdog against a hang
   initial
   begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule : tb
